//--- core/spp_pkg.sv
package spp_pkg;
  // Byte offsets on the register bus
  localparam logic [4:0] ADR_CON = 5'h00;
  localparam logic [4:0] ADR_STAT = 5'h04;
  localparam logic [4:0] ADR_BUF = 5'h08;
  localparam logic [4:0] ADR_ISTAT = 5'h0C;
  localparam logic [4:0] ADR_IMASK = 5'h10;
  // Control register fields
  localparam int B_RXM = 0;
  localparam int B_TXM = 2;
  localparam int B_DIS = 4;
  localparam int B_MST = 5;
  localparam int B_CKP = 6;
  localparam int B_FRM = 7;
  localparam int B_SMP = 8;
  localparam int B_AUD = 9;
  localparam int B_WID = 10;
  localparam int B_ON = 15;
  localparam int B_DIV = 16;
  localparam logic [31:0] CON_RST = 32'h0000_0000;
  localparam logic [31:0] CON_WMASK = 32'h00FF_8FFF;
  localparam logic [31:0] CON_LOCK = 32'h0000_0EF0;
  // Status register fields
  localparam int B_TXCNT = 0;
  localparam int B_RXCNT = 8;
  localparam int B_BUSY = 16;
  // Interrupt bits
  localparam int I_TX = 0;
  localparam int I_RX = 1;
  localparam int I_DONE = 2;
  localparam int I_OVF = 3;
  localparam logic [3:0] IRQ_RST = 4'h0;
  // Word width codes, depths and last bit index
  localparam logic [1:0] W_16 = 2'h1;
  localparam logic [1:0] W_32 = 2'h2;
  localparam logic [4:0] DEP_8 = 5'h10;
  localparam logic [4:0] DEP_16 = 5'h08;
  localparam logic [4:0] DEP_32 = 5'h04;
  localparam logic [4:0] LAST_8 = 5'h07;
  localparam logic [4:0] LAST_16 = 5'h0F;
  localparam logic [4:0] LAST_32 = 5'h1F;

  typedef enum logic [0:0] {
    SPP_IDLE = 1'b0,
    SPP_XFER = 1'b1
  } spp_state_t;

  typedef struct packed {
    logic [31:0] con;
    logic [15:0][31:0] txMem;
    logic [15:0][31:0] rxMem;
    logic [3:0] txWr, txRd, rxWr, rxRd;
    logic [4:0] txCnt, rxCnt;
    logic [3:0] iStat, iMask;
    logic irq;
    logic dWr, dRd;
    logic [4:0] dAdr;
    logic rdy;
    logic [31:0] rdata;
    spp_state_t st;
    logic [31:0] shReg;
    logic [4:0] bitCnt;
    logic rxBit;
    logic [7:0] divCnt;
    logic sckO, sckOe, fsO, fsOe, sdoO, sdiOwn;
    logic sckA, sckB, sckC, fsA, fsB, sdiA, sdiB, ssA, ssB;
  } spp_regs_t;
endpackage : spp_pkg

//--- core/spp_top.sv
// Summary of operation
// - Master-select set makes the port master, clear makes it slave.
// - Serial-in disable set ignores the data input pin and frees it.
// - Tx irq mode 11 not full, 10 half empty, 01 empty, 00 all sent.
// - Rx irq mode 11 full, 10 half full, 01 not empty, 00 empty.
// - Fifo depth is 4, 8 or 16 words for 32, 16 or 8 bit words.
// - Software selects an 8, 16 or 32 bit word width.
// - Receive and transmit words have separate fifo storage.
// - Every completed word can raise an interrupt event.
// - Audio mode forces the clock idle polarity to one.
// - The sample-late bit is unused in framed mode and should be zero.
// - Some configuration bits take writes only while the port is off.
// - The port keeps running in sleep and idle states.
// - Framed mode marks the start of each word with a sync pulse.
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
module spp_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic sdiIn,
  output logic sdoOut,
  input wire logic ssN,
  input wire logic fsIn,
  output logic fsOut,
  output logic fsOe,
  output logic sdiOwned,
  output logic irq
);
  spp_pkg::spp_regs_t r;
  spp_pkg::spp_regs_t n;
  logic on, mst, frm, cpol, late, sdiBit;
  logic [1:0] wid;
  logic [4:0] depth, last;
  logic txFull, txEmpty, rxFull, rxEmpty;
  logic aPh, tick, sEdge, lead, trail, done, start;

  assign on = r.con[spp_pkg::B_ON];
  assign mst = r.con[spp_pkg::B_MST];
  assign frm = r.con[spp_pkg::B_FRM];
  assign wid = r.con[spp_pkg::B_WID+:2];
  assign cpol = r.con[spp_pkg::B_CKP] | r.con[spp_pkg::B_AUD];
  assign late = r.con[spp_pkg::B_SMP] & ~frm;
  assign sdiBit = r.con[spp_pkg::B_DIS] ? 1'h0 : r.sdiB;
  assign depth = (wid == spp_pkg::W_32) ? spp_pkg::DEP_32 :
                 (wid == spp_pkg::W_16) ? spp_pkg::DEP_16 :
                 spp_pkg::DEP_8;
  assign last = (wid == spp_pkg::W_32) ? spp_pkg::LAST_32 :
                (wid == spp_pkg::W_16) ? spp_pkg::LAST_16 :
                spp_pkg::LAST_8;
  assign txFull = r.txCnt == depth;
  assign txEmpty = r.txCnt == 5'h00;
  assign rxFull = r.rxCnt == depth;
  assign rxEmpty = r.rxCnt == 5'h00;
  assign aPh = hsel & htrans[1] & hready;

  // Master edges from the divider, slave edges from the synced pin
  assign tick = (r.st == spp_pkg::SPP_XFER) && (r.divCnt == 8'h00);
  assign sEdge = (r.st == spp_pkg::SPP_XFER) && (r.sckB != r.sckC);
  assign lead = mst ? (tick && r.sckO == cpol)
                    : (sEdge && r.sckB != cpol);
  assign trail = mst ? (tick && r.sckO != cpol)
                     : (sEdge && r.sckB == cpol);
  assign done = on && trail && r.bitCnt == 5'h00;
  assign start = on && (r.st == spp_pkg::SPP_IDLE) &&
                 (mst ? !txEmpty : (frm ? r.fsB : !r.ssB));

  always_comb begin
    logic txPush, txPop, rxPush, rxPop, bitIn, txC, rxC;
    logic [31:0] rdMux, wm, stat, rxWord;
    logic [3:0] ev, clr;
    txPush = 1'h0;
    txPop = 1'h0;
    rxPush = 1'h0;
    rxPop = 1'h0;
    bitIn = late ? sdiBit : r.rxBit;
    rdMux = 32'h0000_0000;
    wm = 32'h0000_0000;
    stat = 32'h0000_0000;
    rxWord = {r.shReg[30:0], bitIn} & (32'hFFFF_FFFF >> (5'h1F - last));
    ev = 4'h0;
    clr = 4'h0;
    txC = 1'h0;
    rxC = 1'h0;
    n = r;

    // Pin synchronisers
    n.sckA = sckIn;
    n.sckB = r.sckA;
    n.sckC = r.sckB;
    n.fsA = fsIn;
    n.fsB = r.fsA;
    n.sdiA = sdiIn;
    n.sdiB = r.sdiA;
    n.ssA = ssN;
    n.ssB = r.ssA;

    // Bus address phase; reads take one wait state
    n.dWr = 1'h0;
    n.dRd = 1'h0;
    if (aPh) begin
      n.dWr = hwrite;
      n.dRd = !hwrite;
      n.dAdr = haddr[4:0];
    end
    n.rdy = !(aPh && !hwrite);

    // Bus write data phase
    if (r.dWr) begin
      unique case (r.dAdr)
        spp_pkg::ADR_CON: begin
          wm = on ? (spp_pkg::CON_WMASK & ~spp_pkg::CON_LOCK)
                  : spp_pkg::CON_WMASK;
          n.con = (r.con & ~wm) | (hwdata & wm);
        end
        spp_pkg::ADR_BUF: txPush = on && !txFull;
        spp_pkg::ADR_ISTAT: clr = hwdata[3:0];
        spp_pkg::ADR_IMASK: n.iMask = hwdata[3:0];
        default: ;
      endcase
    end

    // Bus read: data sampled in the wait cycle
    stat[spp_pkg::B_TXCNT+:5] = r.txCnt;
    stat[spp_pkg::B_RXCNT+:5] = r.rxCnt;
    stat[spp_pkg::B_BUSY] = r.st == spp_pkg::SPP_XFER;
    if (r.dRd) begin
      unique case (r.dAdr)
        spp_pkg::ADR_CON: rdMux = r.con;
        spp_pkg::ADR_STAT: rdMux = stat;
        spp_pkg::ADR_BUF: begin
          rdMux = rxEmpty ? 32'h0000_0000 : r.rxMem[r.rxRd];
          rxPop = !rxEmpty;
        end
        spp_pkg::ADR_ISTAT: rdMux = {28'h000_0000, r.iStat};
        spp_pkg::ADR_IMASK: rdMux = {28'h000_0000, r.iMask};
        default: rdMux = 32'h0000_0000;
      endcase
      n.rdata = rdMux;
    end

    // Shift engine
    unique case (r.st)
      spp_pkg::SPP_IDLE: begin
        n.sckO = cpol;
        n.fsO = 1'h0;
        if (start) begin
          n.st = spp_pkg::SPP_XFER;
          txPop = !txEmpty;
          n.shReg = txEmpty ? 32'h0000_0000
                            : r.txMem[r.txRd] << (5'h1F - last);
          n.bitCnt = last;
          n.divCnt = r.con[spp_pkg::B_DIV+:8];
          n.fsO = mst && frm;
        end
      end
      spp_pkg::SPP_XFER: begin
        if (mst) begin
          if (tick) begin
            n.divCnt = r.con[spp_pkg::B_DIV+:8];
            n.sckO = !r.sckO;
          end else begin
            n.divCnt = r.divCnt - 8'h01;
          end
        end
        if (lead && !late) begin
          n.rxBit = sdiBit;
        end
        if (trail) begin
          n.shReg = {r.shReg[30:0], bitIn};
          n.fsO = 1'h0;
          if (r.bitCnt == 5'h00) begin
            rxPush = 1'h1;
            ev[spp_pkg::I_DONE] = 1'h1;
            n.st = spp_pkg::SPP_IDLE;
          end else begin
            n.bitCnt = r.bitCnt - 5'h01;
          end
        end
        if (!mst && !frm && r.ssB) begin
          n.st = spp_pkg::SPP_IDLE;
        end
      end
    endcase
    n.sdoO = n.shReg[31];

    // Separate transmit and receive stores
    if (txPush) begin
      n.txMem[r.txWr] = hwdata;
      n.txWr = r.txWr + 4'h1;
    end
    if (txPop) begin
      n.txRd = r.txRd + 4'h1;
    end
    if (txPush && !txPop) begin
      n.txCnt = r.txCnt + 5'h01;
    end else if (txPop && !txPush) begin
      n.txCnt = r.txCnt - 5'h01;
    end
    if (rxPush && rxFull && !rxPop) begin
      ev[spp_pkg::I_OVF] = 1'h1;
    end else if (rxPush) begin
      n.rxMem[r.rxWr] = rxWord;
      n.rxWr = r.rxWr + 4'h1;
    end
    if (rxPop) begin
      n.rxRd = r.rxRd + 4'h1;
    end
    if (rxPush && !rxPop && !rxFull) begin
      n.rxCnt = r.rxCnt + 5'h01;
    end else if (rxPop && !rxPush) begin
      n.rxCnt = r.rxCnt - 5'h01;
    end

    // Fill-level interrupt conditions
    unique case (r.con[spp_pkg::B_TXM+:2])
      2'h3: txC = !txFull;
      2'h2: txC = r.txCnt <= (depth >> 1);
      2'h1: txC = txEmpty;
      2'h0: txC = txEmpty && r.st == spp_pkg::SPP_IDLE;
    endcase
    unique case (r.con[spp_pkg::B_RXM+:2])
      2'h3: rxC = rxFull;
      2'h2: rxC = r.rxCnt >= (depth >> 1);
      2'h1: rxC = !rxEmpty;
      2'h0: rxC = rxEmpty;
    endcase
    ev[spp_pkg::I_TX] = on && txC;
    ev[spp_pkg::I_RX] = on && rxC;
    n.iStat = (r.iStat & ~clr) | ev;
    n.irq = |(n.iStat & n.iMask);

    // Turning off flushes both stores and stops the engine
    if (!n.con[spp_pkg::B_ON]) begin
      n.txCnt = 5'h00;
      n.rxCnt = 5'h00;
      n.txWr = 4'h0;
      n.txRd = 4'h0;
      n.rxWr = 4'h0;
      n.rxRd = 4'h0;
      n.st = spp_pkg::SPP_IDLE;
    end
    n.sckOe = n.con[spp_pkg::B_ON] && n.con[spp_pkg::B_MST];
    n.fsOe = n.sckOe && n.con[spp_pkg::B_FRM];
    n.sdiOwn = !n.con[spp_pkg::B_DIS];
  end

  // No sleep gating: runs in low-power states
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.con <= spp_pkg::CON_RST;
      r.iStat <= spp_pkg::IRQ_RST;
      r.iMask <= spp_pkg::IRQ_RST;
      r.rdy <= 1'h1;
      r.st <= spp_pkg::SPP_IDLE;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = r.rdy;
  assign hrdata = r.rdata;
  assign hresp = 1'h0;
  assign sckOut = r.sckO;
  assign sckOe = r.sckOe;
  assign sdoOut = r.sdoO;
  assign fsOut = r.fsO;
  assign fsOe = r.fsOe;
  assign sdiOwned = r.sdiOwn;
  assign irq = r.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_slave_no_drive: assert property (
    !mst |-> !sckOe && !fsOe)
    else $error("slave drives clock or sync");
  a_sdi_ignored: assert property (
    on && r.con[spp_pkg::B_DIS] && trail |=> !r.shReg[0])
    else $error("disabled data input was shifted in");
  a_tx_irq_empty: assert property (
    on && r.con[spp_pkg::B_TXM+:2] == 2'h1 && txEmpty
    |=> r.iStat[spp_pkg::I_TX])
    else $error("tx empty event missing");
  a_rx_irq_full: assert property (
    on && r.con[spp_pkg::B_RXM+:2] == 2'h3 && rxFull
    |=> r.iStat[spp_pkg::I_RX])
    else $error("rx full event missing");
  a_depth_limit: assert property (
    r.txCnt <= depth && r.rxCnt <= depth)
    else $error("fifo count beyond depth");
  a_word_len: assert property (
    r.st == spp_pkg::SPP_XFER && $past(r.st == spp_pkg::SPP_IDLE)
    |-> r.bitCnt == last)
    else $error("word length wrong at start");
  a_fifo_apart: assert property (
    r.dWr && r.dAdr == spp_pkg::ADR_BUF && on &&
    r.st == spp_pkg::SPP_IDLE |=> r.rxCnt == $past(r.rxCnt))
    else $error("tx write disturbed rx store");
  a_done_flag: assert property (
    done |=> r.iStat[spp_pkg::I_DONE] && r.st == spp_pkg::SPP_IDLE)
    else $error("word done event missing");
  a_rx_overflow: assert property (
    done && rxFull && !r.dRd |=> r.iStat[spp_pkg::I_OVF])
    else $error("rx overflow event missing");
  a_tx_irq_half: assert property (
    on && r.con[spp_pkg::B_TXM+:2] == 2'h2 && r.txCnt <= (depth >> 1)
    |=> r.iStat[spp_pkg::I_TX])
    else $error("tx half empty event missing");
  a_audio_pol: assert property (
    r.con[spp_pkg::B_AUD] && $stable(r.con) &&
    r.st == spp_pkg::SPP_IDLE && $past(r.st == spp_pkg::SPP_IDLE)
    |-> r.sckO)
    else $error("audio mode idle clock not high");
  a_locked_cfg: assert property (
    $past(on) |-> (r.con & spp_pkg::CON_LOCK) ==
    ($past(r.con) & spp_pkg::CON_LOCK))
    else $error("locked field changed while on");
  a_frame_start: assert property (
    start && mst && frm |=> r.fsO ##1 r.st == spp_pkg::SPP_XFER
    || !on)
    else $error("frame sync missing at word start");

  c_master_word: cover property (done && mst);
  c_slave_word: cover property (done && !mst);
  c_rx_overflow: cover property (r.iStat[spp_pkg::I_OVF]);
  c_irq_raised: cover property ($rose(irq));
endmodule : spp_top

//--- test/spp_partner.sv
module spp_partner #(
  parameter logic [7:0] INIT = 8'hA5
) (
  input wire logic sck,
  input wire logic oe,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] shReg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic smp;
  initial begin
    shReg = INIT;
    smp = 1'b0;
  end
  // Follows the master clock: sample on rise, shift on fall
  always @(posedge sck) if (oe) smp <= mosi;
  always @(negedge sck) if (oe) shReg <= {shReg[6:0], smp};
  // Released line shows the inverse of its last level
  assign miso = oe ? shReg[7] : ~shReg[7];
endmodule : spp_partner

//--- test/test_serial_peripheral_port.sv
module test_serial_peripheral_port;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [31:0] con;
    int n;
    logic [3:0] ist;
    logic [4:0] cnt;
  } spp_row_t;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, sckOut, sckOe, sdiIn, sdoOut;
  logic fsOut, fsOe, sdiOwned, irq;
  logic [31:0] hrdata, rv;
  logic [7:0] farByte;
  logic [7:0] slvIn;
  logic sckPin = 1'b0;
  logic ssPin = 1'b1;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  spp_row_t rows [10] = '{
    '{32'h0000_800F, 17, 4'h0, 5'h10},
    '{32'h0000_8008, 8, 4'h3, 5'h08},
    '{32'h0000_8009, 9, 4'h0, 5'h09},
    '{32'h0000_8006, 1, 4'h0, 5'h01},
    '{32'h0000_8007, 0, 4'h1, 5'h00},
    '{32'h0000_8000, 0, 4'h3, 5'h00},
    '{32'h0000_840D, 9, 4'h0, 5'h08},
    '{32'h0000_880A, 2, 4'h1, 5'h02},
    '{32'h0000_880F, 5, 4'h0, 5'h04},
    '{32'h0000_8408, 5, 4'h2, 5'h05}};

  spp_top spp_top_inst (
    .mclk(mclk),
    .arst_n(arst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .sckIn(sckPin),
    .sckOut(sckOut),
    .sckOe(sckOe),
    .sdiIn(sdiIn),
    .sdoOut(sdoOut),
    .ssN(ssPin),
    .fsIn(1'b0),
    .fsOut(fsOut),
    .fsOe(fsOe),
    .sdiOwned(sdiOwned),
    .irq(irq)
  );
  spp_partner spp_partner_inst (
    .sck(sckOut),
    .oe(sckOe),
    .mosi(sdoOut),
    .miso(sdiIn),
    .shReg(farByte)
  );

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus

  task wrd(input logic [4:0] a, input logic [31:0] w, input logic [31:0] e);
    bus(1'b1, a, w);
    bus(1'b0, a, 32'h0);
    chk("readback", e, rv);
  endtask : wrd

  task cfg(input logic [31:0] v);
    bus(1'b1, spp_pkg::ADR_CON, 32'h0);
    @(posedge mclk);
    bus(1'b1, spp_pkg::ADR_CON, v);
  endtask : cfg

  task wait_done;
    for (int i = 0; i < 60; i++) begin
      bus(1'b0, spp_pkg::ADR_ISTAT, 32'h0);
      if (rv[spp_pkg::I_DONE] === 1'b1) break;
    end
  endtask : wait_done

  initial begin
    int i;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    foreach (rows[r]) begin
      cfg(rows[r].con);
      for (i = 0; i < rows[r].n; i++) bus(1'b1, spp_pkg::ADR_BUF, i);
      bus(1'b1, spp_pkg::ADR_ISTAT, 32'h0000_000F);
      bus(1'b0, spp_pkg::ADR_ISTAT, 32'h0);
      chk("istat", {28'h0, rows[r].ist}, rv);
      bus(1'b0, spp_pkg::ADR_STAT, 32'h0);
      chk("counts", {27'h0, rows[r].cnt}, rv & 32'h1F1F);
    end
    $display("done: fill rows");
    bus(1'b1, spp_pkg::ADR_IMASK, 32'h0000_0002);
    repeat (3) @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, spp_pkg::ADR_IMASK, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    cfg(32'h0);
    wrd(spp_pkg::ADR_CON, 32'hFFFF_710F, 32'h00FF_010F);
    wrd(spp_pkg::ADR_CON, 32'h0000_0ED0, 32'h0000_0ED0);
    wrd(spp_pkg::ADR_CON, 32'h0000_8ED0, 32'h0000_8ED0);
    wrd(spp_pkg::ADR_CON, 32'h0000_8000, 32'h0000_8ED0);
    wrd(spp_pkg::ADR_CON, 32'h0000_0000, 32'h0000_0ED0);
    wrd(spp_pkg::ADR_CON, 32'h0000_0000, 32'h0000_0000);
    wrd(5'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    wrd(spp_pkg::ADR_IMASK, 32'hFFFF_FFFF, 32'h0000_000F);
    $display("done: registers");
    // Master, divider 3, both irq modes 00
    cfg(32'h0003_8020);
    bus(1'b1, spp_pkg::ADR_IMASK, 32'h0000_0004);
    bus(1'b1, spp_pkg::ADR_ISTAT, 32'h0000_000F);
    bus(1'b1, spp_pkg::ADR_BUF, 32'h0000_003C);
    chk("sckOe", 32'h1, {31'h0, sckOe});
    wait_done();
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b0, spp_pkg::ADR_BUF, 32'h0);
    chk("rx word", 32'h0000_00A5, rv);
    chk("far word", 32'h3C, {24'h0, farByte});
    bus(1'b1, spp_pkg::ADR_ISTAT, 32'h0000_0004);
    repeat (3) @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("done: master word");
    cfg(32'h0003_80A0); // sample-late left 0
    bus(1'b1, spp_pkg::ADR_BUF, 32'h0000_0081);
    for (i = 0; i < 100 && fsOut !== 1'b1; i++) @(posedge mclk);
    chk("fsOut", 32'h1, {31'h0, fsOut});
    chk("fsOe", 32'h1, {31'h0, fsOe});
    wait_done();
    // Slave word, bench drives a 200 ns link clock
    cfg(32'h0000_8000);
    bus(1'b1, spp_pkg::ADR_BUF, 32'h0000_005A);
    bus(1'b1, spp_pkg::ADR_ISTAT, 32'h0000_000F);
    ssPin <= 1'b0;
    repeat (8) @(posedge mclk);
    for (i = 0; i < 8; i++) begin
      sckPin <= 1'b1;
      slvIn <= {slvIn[6:0], sdoOut};
      repeat (4) @(posedge mclk);
      sckPin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
    ssPin <= 1'b1;
    chk("slave sdo", 32'h5A, {24'h0, slvIn});
    chk("slave sckOe", 32'h0, {31'h0, sckOe});
    bus(1'b0, spp_pkg::ADR_ISTAT, 32'h0);
    chk("slave done", 32'h4, rv & 32'h4);
    bus(1'b0, spp_pkg::ADR_BUF, 32'h0);
    chk("slave rx", {24'h0, {8{~farByte[7]}}}, rv);
    $display("done: slave word");
    cfg(32'h0003_8220);
    repeat (4) @(posedge mclk);
    chk("sckOut", 32'h1, {31'h0, sckOut});
    cfg(32'h0000_0010);
    repeat (3) @(posedge mclk);
    chk("sdiOwned", 32'h0, {31'h0, sdiOwned});
    cfg(32'h0000_0000);
    repeat (3) @(posedge mclk);
    chk("sdiOwned", 32'h1, {31'h0, sdiOwned});
    $display("done: pins");
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    chk("sckOe", 32'h0, {31'h0, sckOe});
    chk("hresp", 32'h0, {31'h0, hresp});
    arst_n <= 1'b1;
    @(posedge mclk);
    wrd(spp_pkg::ADR_IMASK, 32'h0, 32'h0);
    bus(1'b0, spp_pkg::ADR_CON, 32'h0);
    chk("con reset", spp_pkg::CON_RST, rv);
    $display("done: reset");
    end_of_test();
  end
endmodule : test_serial_peripheral_port
